// File: core/stepper_pkg.sv
package stepper_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEAD_NS       = 500;
  localparam int BLANK_NS      = 3200;
  localparam int OFF_LVL0_NS   = 10000;
  localparam int OFF_LVL1_NS   = 7000;
  localparam int OFF_LVL2_NS   = 4000;
  localparam int OPEN_DLY_NS   = 20000;
  localparam int DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_LVL0_CYC  = (OFF_LVL0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_LVL1_CYC  = (OFF_LVL1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_LVL2_CYC  = (OFF_LVL2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_DLY_CYC  = OPEN_DLY_NS / CLK_PERIOD_NS;
  localparam int OPEN_CONFIRM  = 3;
  localparam int TMR_W         = 16;
  localparam logic [1:0] LVL0  = 2'h0;
  localparam logic [1:0] LVL1  = 2'h1;
  localparam logic [1:0] LVL2  = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_BLANK = 7'h02,
    ST_ON    = 7'h04,
    ST_DEADA = 7'h08,
    ST_SYNC  = 7'h10,
    ST_DEADB = 7'h20,
    ST_FAULT = 7'h40
  } pwm_state_e;
endpackage : stepper_pkg

// File: core/tmr_if.sv
`timescale 1ns/1ps
interface tmr_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] value;
  logic [W-1:0] remain;
  logic         done;
  modport ctrl (output load, output value, input remain, input done);
  modport tmr  (input load, input value, output remain, output done);
endinterface : tmr_if

// File: core/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  tmr_if.tmr       t
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Loading restarts the interval so a new phase never inherits an old count.
  always_comb begin
    cnt_d = cnt_q;
    if (t.load) begin
      cnt_d = t.value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign t.remain = cnt_q;
  // Done must not look at load: the controller reloads on done, and that would close a loop.
  assign t.done   = (cnt_q == W'(1));
endmodule : interval_timer

// File: core/stepper_pwm_offtime_protection.sv
`timescale 1ns/1ps
module stepper_pwm_offtime_protection
  import stepper_pkg::*;
#(
  parameter int OFF0  = stepper_pkg::OFF_LVL0_CYC,
  parameter int OFF1  = stepper_pkg::OFF_LVL1_CYC,
  parameter int OFF2  = stepper_pkg::OFF_LVL2_CYC,
  parameter int BLANK = stepper_pkg::BLANK_CYC,
  parameter int DEAD  = stepper_pkg::DEAD_CYC,
  parameter int ODLY  = stepper_pkg::OPEN_DLY_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       DRIVE_EN,
  input  wire logic [1:0] RATIO_LEVEL,
  input  wire logic       SENSE_TRIP,
  input  wire logic       SHORT_TRIP,
  input  wire logic       SENSE_POS,
  input  wire logic       OVER_TEMP,
  output logic            GATE_DRIVE,
  output logic            GATE_SYNC,
  output logic            FAULT_SHORT,
  output logic            FAULT_OPEN,
  output logic            FAULT_TEMP,
  output logic            OUT_DISABLED
);
  import stepper_pkg::*;

  localparam int CW = 2;
  localparam int NIN = 6;

  // Every input is asynchronous to the oscillator, so all pass two flops.
  logic [NIN-1:0] raw;
  logic [NIN-1:0] sy1_q;
  logic [NIN-1:0] sy2_q;
  assign raw = {DRIVE_EN, RATIO_LEVEL, SENSE_TRIP, SHORT_TRIP, SENSE_POS};
  logic otemp1_q;
  logic otemp2_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sy1_q    <= '0;
      sy2_q    <= '0;
      otemp1_q <= 1'b0;
      otemp2_q <= 1'b0;
    end else begin
      sy1_q    <= raw;
      sy2_q    <= sy1_q;
      otemp1_q <= OVER_TEMP;
      otemp2_q <= otemp1_q;
    end
  end

  logic       en_s;
  logic [1:0] lvl_s;
  logic       trip_s;
  logic       short_s;
  logic       pos_s;
  logic       temp_s;
  assign {en_s, lvl_s, trip_s, short_s, pos_s} = sy2_q;
  assign temp_s = otemp2_q;

  tmr_if #(.W(TMR_W)) tif ();
  interval_timer #(.W(TMR_W)) u_tmr (
    .clk   (CLK),
    .rst_b (RST_B),
    .t     (tif.tmr)
  );

  pwm_state_e      st_q;
  pwm_state_e      st_d;
  logic [TMR_W-1:0] off_len_q;
  logic [TMR_W-1:0] off_len_d;
  logic [TMR_W-1:0] off_sel;
  logic            gate_on_q;
  logic            gate_on_d;
  logic            gate_sync_q;
  logic            gate_sync_d;
  logic            f_short_q;
  logic            f_short_d;
  logic            f_open_q;
  logic            f_open_d;
  logic            f_temp_q;
  logic            f_temp_d;
  logic            pos_seen_q;
  logic            pos_seen_d;
  logic [CW-1:0]   open_cnt_q;
  logic [CW-1:0]   open_cnt_d;
  logic            confirmed_q;
  logic            confirmed_d;
  logic [TMR_W-1:0] brk_q;
  logic [TMR_W-1:0] brk_d;
  logic            in_off;
  logic            off_end;
  logic            any_fault;

  // The fourth ratio code has no level of its own and uses the shortest one.
  always_comb begin
    unique case (lvl_s)
      LVL0:    off_sel = TMR_W'(OFF0);
      LVL1:    off_sel = TMR_W'(OFF1);
      default: off_sel = TMR_W'(OFF2);
    endcase
  end

  assign in_off    = (st_q == ST_DEADA) || (st_q == ST_SYNC) || (st_q == ST_DEADB);
  assign off_end   = (st_q == ST_DEADB) && tif.done;
  assign any_fault = f_short_d || f_open_d || f_temp_d;

  // Fault latches only ever set; the power-on reset is their only clear.
  always_comb begin
    f_short_d = f_short_q || short_s;
    f_temp_d  = f_temp_q || temp_s;
    f_open_d  = f_open_q;
    pos_seen_d  = pos_seen_q;
    open_cnt_d  = open_cnt_q;
    confirmed_d = confirmed_q;
    brk_d       = brk_q;
    if (in_off && pos_s) begin
      pos_seen_d = 1'b1;
      if (confirmed_q) begin
        brk_d = brk_q + 1'b1;
      end
    end
    if (confirmed_q && (brk_q > TMR_W'(ODLY))) begin
      f_open_d = 1'b1;
    end
    if (off_end) begin
      pos_seen_d = 1'b0;
      if (pos_seen_q || pos_s) begin
        if (open_cnt_q == CW'(OPEN_CONFIRM - 1)) begin
          confirmed_d = 1'b1;
        end else begin
          open_cnt_d = open_cnt_q + 1'b1;
        end
      end else begin
        // A clean interval means the earlier positives were surge noise.
        open_cnt_d  = '0;
        confirmed_d = 1'b0;
        brk_d       = '0;
      end
    end
  end

  always_comb begin
    st_d      = st_q;
    off_len_d = off_len_q;
    tif.load  = 1'b0;
    tif.value = '0;
    if (any_fault) begin
      st_d = ST_FAULT;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (en_s) begin
            st_d      = ST_BLANK;
            tif.load  = 1'b1;
            tif.value = TMR_W'(BLANK);
          end
        end
        ST_BLANK: begin
          if (!en_s) begin
            st_d = ST_IDLE;
          end else if (tif.done) begin
            st_d = ST_ON;
          end
        end
        ST_ON: begin
          if (!en_s) begin
            st_d = ST_IDLE;
          end else if (trip_s) begin
            st_d      = ST_DEADA;
            tif.load  = 1'b1;
            tif.value = off_sel;
            off_len_d = off_sel;
          end
        end
        ST_DEADA: begin
          // The timer was loaded at turn-off, so this leaves exactly DEAD low cycles.
          if (tif.remain <= off_len_q - TMR_W'(DEAD - 1)) begin
            st_d = ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (tif.remain <= TMR_W'(DEAD + 1)) begin
            st_d = ST_DEADB;
          end
        end
        ST_DEADB: begin
          if (tif.done) begin
            if (en_s) begin
              st_d      = ST_BLANK;
              tif.load  = 1'b1;
              tif.value = TMR_W'(BLANK);
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_FAULT: begin
          st_d = ST_FAULT;
        end
      endcase
    end
    gate_on_d   = (st_d == ST_BLANK) || (st_d == ST_ON);
    gate_sync_d = (st_d == ST_SYNC);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q        <= ST_IDLE;
      off_len_q   <= '0;
      gate_on_q   <= 1'b0;
      gate_sync_q <= 1'b0;
      f_short_q   <= 1'b0;
      f_open_q    <= 1'b0;
      f_temp_q    <= 1'b0;
      pos_seen_q  <= 1'b0;
      open_cnt_q  <= '0;
      confirmed_q <= 1'b0;
      brk_q       <= '0;
    end else begin
      st_q        <= st_d;
      off_len_q   <= off_len_d;
      gate_on_q   <= gate_on_d;
      gate_sync_q <= gate_sync_d;
      f_short_q   <= f_short_d;
      f_open_q    <= f_open_d;
      f_temp_q    <= f_temp_d;
      pos_seen_q  <= pos_seen_d;
      open_cnt_q  <= open_cnt_d;
      confirmed_q <= confirmed_d;
      brk_q       <= brk_d;
    end
  end

  assign GATE_DRIVE   = gate_on_q;
  assign GATE_SYNC    = gate_sync_q;
  assign FAULT_SHORT  = f_short_q;
  assign FAULT_OPEN   = f_open_q;
  assign FAULT_TEMP   = f_temp_q;
  assign OUT_DISABLED = (st_q == ST_FAULT);

  // Helper: cycles both gates have been low since the last of the two gates fell.
  logic [TMR_W-1:0] low_run_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      low_run_q <= '0;
    end else if (gate_on_q || gate_sync_q) begin
      low_run_q <= '0;
    end else if (low_run_q != '1) begin
      low_run_q <= low_run_q + 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_off_fixed;
    $rose(gate_on_q) && ($past(st_q) == ST_DEADB) |-> $past(tif.remain) == TMR_W'(1);
  endproperty
  a_off_fixed: assert property (p_off_fixed) else $error("on before off time end");

  property p_off_sel;
    (st_q == ST_ON) && (st_d == ST_DEADA) |=>
      off_len_q == (($past(lvl_s) == LVL0) ? TMR_W'(OFF0) :
                    ($past(lvl_s) == LVL1) ? TMR_W'(OFF1) : TMR_W'(OFF2))
      && tif.remain == off_len_q;
  endproperty
  a_off_sel: assert property (p_off_sel) else $error("off length not from level");

  property p_no_overlap;
    !(gate_on_q && gate_sync_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

  property p_dead_before_sync;
    $rose(gate_sync_q) |-> low_run_q == TMR_W'(DEAD);
  endproperty
  a_dead_before_sync: assert property (p_dead_before_sync) else $error("no dead time");

  property p_dead_after_sync;
    $rose(gate_on_q) && ($past(st_q) == ST_DEADB) |-> low_run_q == TMR_W'(DEAD);
  endproperty
  a_dead_after_sync: assert property (p_dead_after_sync)
    else $error("no dead time before turn-on");

  property p_short_off;
    short_s |=> f_short_q && !gate_on_q && !gate_sync_q && OUT_DISABLED;
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not disable");

  property p_short_hold;
    f_short_q |=> f_short_q && OUT_DISABLED;
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("short fault cleared");

  property p_temp_off;
    temp_s |=> f_temp_q && !gate_on_q ##1 f_temp_q;
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("temp did not latch");

  property p_trip_ends_on;
    (st_q == ST_ON) && trip_s && en_s && !any_fault |=> !gate_on_q && (st_q == ST_DEADA);
  endproperty
  a_trip_ends_on: assert property (p_trip_ends_on) else $error("trip ignored in on");

  property p_blank;
    (st_q == ST_BLANK) && (tif.remain != TMR_W'(1)) && en_s && !any_fault
      |=> st_q == ST_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("trip taken in blanking");

  property p_clean_clears;
    off_end && !pos_seen_q && !pos_s |=> open_cnt_q == '0 && !confirmed_q;
  endproperty
  a_clean_clears: assert property (p_clean_clears) else $error("open count kept");

  property p_open_needs_confirm;
    $rose(confirmed_q) |-> $past(open_cnt_q) == CW'(OPEN_CONFIRM - 1) && $past(off_end);
  endproperty
  a_open_needs_confirm: assert property (p_open_needs_confirm) else $error("early open");

  c_sync:  cover property (gate_sync_q ##1 !gate_sync_q);
  c_short: cover property ($rose(f_short_q));
  c_open:  cover property ($rose(f_open_q));
  c_cycle: cover property ($rose(gate_on_q) ##[1:400] $fell(gate_on_q));
endmodule : stepper_pwm_offtime_protection

// File: sim/coil_model.sv
`timescale 1ns/1ps
module coil_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       gate_drive,
  input  wire logic       open_en,
  input  wire logic       short_en,
  input  wire logic [7:0] trip_cnt,
  output logic            sense_trip,
  output logic            sense_pos,
  output logic            short_trip
);
  logic [7:0] ramp_q;
  logic [7:0] ramp_d;

  // Coil current rises only while the driving gate is on.
  always_comb begin
    ramp_d = gate_drive ? ramp_q + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_q <= 8'h00;
    end else begin
      ramp_q <= ramp_d;
    end
  end

  assign sense_trip = gate_drive && (ramp_q >= trip_cnt);
  // An open coil shows a positive sense voltage whenever the drive is off.
  assign sense_pos  = open_en && !gate_drive;
  assign short_trip = short_en && gate_drive;
endmodule : coil_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int OFF0 = 40, OFF1 = 30, OFF2 = 25, BLANK = 4, DEAD = 2, ODLY = 20;
  logic       clk = 1'b0, rst_b = 1'b0, drive_en = 1'b0, over_temp = 1'b0;
  logic [1:0] ratio = 2'h0;
  logic       open_en = 1'b0, short_en = 1'b0;
  logic [7:0] trip_cnt = 8'h08;
  logic       sense_trip, short_trip, sense_pos;
  logic       gate_drive, gate_sync, fault_short, fault_open, fault_temp, out_disabled;
  int         fails = 0, n_checks = 0;

  always #25 clk = ~clk;

  stepper_pwm_offtime_protection #(.OFF0(OFF0), .OFF1(OFF1), .OFF2(OFF2), .BLANK(BLANK),
    .DEAD(DEAD), .ODLY(ODLY)) i_stepper_pwm_offtime_protection (
    .CLK(clk), .RST_B(rst_b), .DRIVE_EN(drive_en), .RATIO_LEVEL(ratio),
    .SENSE_TRIP(sense_trip), .SHORT_TRIP(short_trip), .SENSE_POS(sense_pos),
    .OVER_TEMP(over_temp), .GATE_DRIVE(gate_drive), .GATE_SYNC(gate_sync),
    .FAULT_SHORT(fault_short), .FAULT_OPEN(fault_open), .FAULT_TEMP(fault_temp),
    .OUT_DISABLED(out_disabled));

  coil_model i_coil_model (.clk(clk), .rst_b(rst_b), .gate_drive(gate_drive),
    .open_en(open_en), .short_en(short_en), .trip_cnt(trip_cnt),
    .sense_trip(sense_trip), .sense_pos(sense_pos), .short_trip(short_trip));

  task automatic stop_test();
    $display("checks %0d, failures %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    fails++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      fail(msg);
    end
  endtask : chk

  always @(negedge clk) begin
    if (gate_drive === 1'b1 && gate_sync === 1'b1) begin
      fail("both gates on");
    end
    if (out_disabled === 1'b1 && (gate_drive !== 1'b0 || gate_sync !== 1'b0)) begin
      fail("gate on while disabled");
    end
  end

  task automatic wait_gate(input logic v);
    int n;
    n = 0;
    while (gate_drive !== v) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        fail("gate wait timeout");
        stop_test();
      end
    end
  endtask : wait_gate

  // Times one full ON phase and the OFF interval that follows it.
  task automatic measure(output int hi, output int lo, output int dd, output int tl);
    int sy;
    wait_gate(1'b0);
    wait_gate(1'b1);
    hi = 0; lo = 0; dd = 0; tl = 0; sy = 0;
    while (gate_drive === 1'b1 && hi < 3000) begin
      hi++;
      @(negedge clk);
    end
    while (gate_drive === 1'b0 && lo < 3000) begin
      lo++;
      if (gate_sync === 1'b1) sy++;
      else if (sy == 0) dd++;
      else tl++;
      @(negedge clk);
    end
    if (sy == 0) dd = -1;
    if (hi >= 3000 || lo >= 3000) begin
      fail("phase length timeout");
      stop_test();
    end
  endtask : measure

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    chk({gate_drive, gate_sync, fault_short, fault_open, fault_temp, out_disabled}
        === 6'h00, "reset state");
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic t_off();
    int hi, lo, dd, tl;
    int exp_lo[4] = '{OFF0, OFF1, OFF2, OFF2};
    for (int l = 0; l < 4; l++) begin
      @(posedge clk);
      ratio <= l[1:0];
      measure(hi, lo, dd, tl);
      measure(hi, lo, dd, tl);
      chk(lo == exp_lo[l], "off interval length");
      chk(dd == DEAD && tl == DEAD, "dead time or missing sync");
    end
  endtask : t_off

  task automatic t_on();
    int hi, lo, dd, tl, lim;
    int tcs[2] = '{0, 20};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      trip_cnt <= tcs[i][7:0];
      measure(hi, lo, dd, tl);
      measure(hi, lo, dd, tl);
      lim = (tcs[i] > BLANK) ? tcs[i] : BLANK;
      chk(hi >= lim && hi <= lim + 6, "on phase length");
    end
    @(posedge clk);
    trip_cnt <= 8'h08;
  endtask : t_on

  // Dropping the enable in an ON phase must end it and keep both gates low.
  task automatic t_idle();
    wait_gate(1'b0);
    wait_gate(1'b1);
    @(posedge clk);
    drive_en <= 1'b0;
    repeat (4) @(negedge clk);
    chk(gate_drive === 1'b0 && gate_sync === 1'b0, "enable drop ignored");
    repeat (60) @(negedge clk);
    chk(gate_drive === 1'b0 && gate_sync === 1'b0, "gate on while idle");
    @(posedge clk);
    drive_en <= 1'b1;
  endtask : t_idle

  task automatic t_open();
    int n;
    wait_gate(1'b1);
    @(posedge clk);
    open_en <= 1'b1;
    repeat (2) begin wait_gate(1'b0); wait_gate(1'b1); end
    chk(fault_open === 1'b0, "open fault after two intervals");
    @(posedge clk);
    open_en <= 1'b0;
    wait_gate(1'b0);
    wait_gate(1'b1);
    @(posedge clk);
    open_en <= 1'b1;
    repeat (2) begin wait_gate(1'b0); wait_gate(1'b1); end
    chk(fault_open === 1'b0, "open count not cleared");
    n = 0;
    while (fault_open !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(fault_open === 1'b1 && out_disabled === 1'b1, "open fault missing");
    @(posedge clk);
    open_en <= 1'b0;
    repeat (50) @(negedge clk);
    chk(fault_open === 1'b1 && out_disabled === 1'b1, "open fault released");
    do_reset();
  endtask : t_open

  task automatic t_fault(input int k);
    wait_gate(1'b1);
    @(posedge clk);
    if (k == 0) short_en <= 1'b1;
    else over_temp <= 1'b1;
    repeat (5) @(negedge clk);
    chk((k == 0 ? fault_short : fault_temp) === 1'b1 && out_disabled === 1'b1,
        "fault not taken");
    @(posedge clk);
    short_en <= 1'b0;
    over_temp <= 1'b0;
    repeat (50) @(negedge clk);
    chk((k == 0 ? fault_short : fault_temp) === 1'b1 && out_disabled === 1'b1,
        "fault released");
    do_reset();
  endtask : t_fault

  initial begin
    do_reset();
    @(posedge clk);
    drive_en <= 1'b1;
    t_off();
    t_on();
    t_idle();
    t_open();
    t_fault(0);
    t_fault(1);
    stop_test();
  end
endmodule : testbench
